// >>> rtl/owl_pkg.sv
// Shared constants, types and helper functions for the operand width lookup block.
package owl_pkg;

    localparam int OWL_VAL_W = 16;
    localparam int OWL_IDX_W = 8;
    localparam int OWL_ENTRIES = 4;
    localparam int OWL_BYTE_SHIFT = 3;

    localparam logic [7:0] OWL_SR_MAP_0 = 8'h00;
    localparam logic [7:0] OWL_SR_MAP_1 = 8'h01;
    localparam logic [7:0] OWL_SR_MAP_2 = 8'h02;
    localparam logic [7:0] OWL_SR_MAP_3 = 8'h03;
    localparam logic [7:0] OWL_SR_WIDEST = 8'h04;
    localparam logic [7:0] OWL_SR_SIMD_LIMIT = 8'h05;

    localparam logic [3:0][15:0] OWL_MAP_RESET = {16'h0008, 16'h0004, 16'h0002, 16'h0001};
    localparam logic [15:0] OWL_WIDEST_RESET = 16'h0008;
    localparam logic [15:0] OWL_SIMD_LIMIT_RESET = 16'h0040;
    localparam logic [15:0] OWL_ZERO = 16'h0000;
    localparam logic [15:0] OWL_ONE = 16'h0001;

    typedef enum logic [2:0] {
        OWL_TRAP_NONE = 3'b000,
        OWL_TRAP_NO_REG = 3'b001,
        OWL_TRAP_NO_ACCESS = 3'b010,
        OWL_TRAP_HARDWIRED = 3'b011,
        OWL_TRAP_INCOHERENT = 3'b100
    } owl_trap_t;

    typedef enum logic [1:0] {
        OWL_ST_IDLE = 2'b00,
        OWL_ST_CHECK = 2'b01,
        OWL_ST_COMMIT = 2'b10
    } owl_state_t;

    typedef enum logic [1:0] {
        OWL_KIND_NONE = 2'b00,
        OWL_KIND_MAP = 2'b01,
        OWL_KIND_WIDEST = 2'b10,
        OWL_KIND_SIMD = 2'b11
    } owl_kind_t;

    typedef struct packed {
        logic valid;
        logic [1:0] width_field;
        logic simd;
    } owl_dec_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] width_bytes;
        logic simd;
        logic trap;
    } owl_dec_rsp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] index;
        logic [15:0] wdata;
    } owl_sr_req_t;

    typedef struct packed {
        logic valid;
        logic trap;
        owl_trap_t cause;
        logic [15:0] rdata;
    } owl_sr_rsp_t;

    function automatic logic owl_is_pow2(input logic [15:0] v);
        owl_is_pow2 = (v != OWL_ZERO) && ((v & (v - OWL_ONE)) == OWL_ZERO);
    endfunction

    function automatic owl_kind_t owl_sr_kind(input logic [7:0] index);
        if (index <= OWL_SR_MAP_3)
            owl_sr_kind = OWL_KIND_MAP;
        else if (index == OWL_SR_WIDEST)
            owl_sr_kind = OWL_KIND_WIDEST;
        else if (index == OWL_SR_SIMD_LIMIT)
            owl_sr_kind = OWL_KIND_SIMD;
        else
            owl_sr_kind = OWL_KIND_NONE;
    endfunction

    function automatic logic [15:0] owl_lookup(input logic [3:0][15:0] map,
                                               input logic [1:0] field);
        owl_lookup = map[field];
    endfunction

endpackage

// >>> rtl/owl_width_map.sv
// Four programmable width map entries holding the byte width of each field value.
`timescale 1ns/1ps
`default_nettype none
module owl_width_map
    import owl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [15:0] wr_value,
    output logic [3:0][15:0] entry
);

    genvar i;
    generate
        for (i = 0; i < OWL_ENTRIES; i = i + 1)
        begin : g_entry
            always_ff @(posedge clk)
            begin
                if (rst)
                    entry[i] <= OWL_MAP_RESET[i]; // [RULE_02]
                else if (ce && wr_en && (wr_sel == 2'(i)))
                    entry[i] <= wr_value; // [RULE_04] [RULE_03]
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> rtl/owl_decoder.sv
// Decode-stage operand width lookup with guarded special register access.
//
// Overview of operation
// [RULE_01] Two-bit width field of each data instruction indexes a four-entry table.
// [RULE_02] After reset the table maps 00,01,10,11 to 1,2,4,8 bytes.
// [RULE_03] The table lives in the decoder; entries may hold any power of two; the code also traps values above WIDEST_BYTES.
// [RULE_04] Four width map registers, one per field value; a write replaces it.
// [RULE_05] Width map writes need privilege and a coherent width, else a trap.
// [RULE_06] A read-only register returns the widest width this build supports.
// [RULE_07] A build with hardwired defaults traps on every width map write.
// [RULE_08] Software on a hardwired build does not try to modify the map.
// [RULE_09] A read-only register reports the largest SIMD element width in bits.
// [RULE_10] Each data instruction carries a SIMD flag passed on with its width.
// [RULE_11] Special registers are reached only by the dedicated access port.
// [RULE_12] Access traps for a missing register or a forbidden context.
// [RULE_13] Each access completes atomically and never stalls decoding.
// [RULE_14] A decoded width beyond what the build handles raises a trap.
// [RULE_15] A committed map write affects only instructions decoded afterwards.
`timescale 1ns/1ps
`default_nettype none
module owl_decoder
    import owl_pkg::*;
#(
    parameter logic HARDWIRED = 1'b0,
    parameter logic [15:0] WIDEST_BYTES = OWL_WIDEST_RESET,
    parameter logic [15:0] SIMD_LIMIT_BITS = OWL_SIMD_LIMIT_RESET
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire owl_dec_req_t DEC_REQ,
    output owl_dec_rsp_t DEC_RSP,
    input wire owl_sr_req_t SR_REQ,
    input wire logic SR_PRIV,
    output logic SR_READY,
    output owl_sr_rsp_t SR_RSP
);

    owl_state_t state;
    owl_state_t next_state;
    owl_sr_req_t held_req;
    logic held_priv;
    owl_trap_t cause;
    owl_trap_t next_cause;
    owl_kind_t held_kind;
    logic [3:0][15:0] map_entry;
    logic map_wr_en;
    logic [15:0] dec_width;
    logic [18:0] dec_width_bits;
    logic dec_too_wide;
    logic [15:0] read_value;

    // The access port only accepts work while no other access is in flight.
    assign SR_READY = (state == OWL_ST_IDLE); // [RULE_13]

    always_comb
    begin
        next_state = state;
        case (state)
            OWL_ST_IDLE:
            begin
                if (SR_REQ.valid)
                    next_state = OWL_ST_CHECK; // [RULE_11]
            end
            OWL_ST_CHECK:
            begin
                next_state = OWL_ST_COMMIT;
            end
            OWL_ST_COMMIT:
            begin
                next_state = OWL_ST_IDLE; // [RULE_13]
            end
            default:
            begin
                next_state = OWL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            state <= OWL_ST_IDLE;
        else if (CE)
            state <= next_state;
    end

    // The request and the context it was issued in are captured together.
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            held_req <= '0;
            held_priv <= 1'b0;
        end
        else if (CE && (state == OWL_ST_IDLE) && SR_REQ.valid)
        begin
            held_req <= SR_REQ;
            held_priv <= SR_PRIV;
        end
    end

    assign held_kind = owl_sr_kind(held_req.index);

    // Checks in priority order: existence, context, fixed register, width.
    always_comb
    begin
        next_cause = OWL_TRAP_NONE;
        if (held_kind == OWL_KIND_NONE)
        begin
            next_cause = OWL_TRAP_NO_REG; // [RULE_12]
        end
        else if (held_req.write)
        begin
            if (!held_priv)
            begin
                next_cause = OWL_TRAP_NO_ACCESS; // [RULE_12] [RULE_05]
            end
            else if (held_kind != OWL_KIND_MAP)
            begin
                next_cause = OWL_TRAP_HARDWIRED; // [RULE_06] [RULE_09]
            end
            else if (HARDWIRED)
            begin
                next_cause = OWL_TRAP_HARDWIRED; // [RULE_07]
            end
            else if (!owl_is_pow2(held_req.wdata) || (held_req.wdata > WIDEST_BYTES))
            begin
                next_cause = OWL_TRAP_INCOHERENT; // [RULE_05] [RULE_03]
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            cause <= OWL_TRAP_NONE;
        else if (CE && (state == OWL_ST_CHECK))
            cause <= next_cause;
    end

    // The write lands in one edge so no decode ever sees a half update.
    assign map_wr_en = (state == OWL_ST_COMMIT) && held_req.write
                       && (cause == OWL_TRAP_NONE); // [RULE_04] [RULE_13]

    owl_width_map u_width_map (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .wr_en(map_wr_en),
        .wr_sel(held_req.index[1:0]),
        .wr_value(held_req.wdata),
        .entry(map_entry)
    );

    always_comb
    begin
        read_value = OWL_ZERO;
        case (held_kind)
            OWL_KIND_MAP:
            begin
                read_value = owl_lookup(map_entry, held_req.index[1:0]);
            end
            OWL_KIND_WIDEST:
            begin
                read_value = WIDEST_BYTES; // [RULE_06]
            end
            OWL_KIND_SIMD:
            begin
                read_value = SIMD_LIMIT_BITS; // [RULE_09]
            end
            default:
            begin
                read_value = OWL_ZERO;
            end
        endcase
    end

    // The answer is a one-cycle pulse after the commit cycle.
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            SR_RSP <= '0;
        end
        else if (CE)
        begin
            SR_RSP.valid <= (state == OWL_ST_COMMIT);
            if (state == OWL_ST_COMMIT)
            begin
                SR_RSP.trap <= (cause != OWL_TRAP_NONE); // [RULE_12]
                SR_RSP.cause <= cause;
                if (!held_req.write && (cause == OWL_TRAP_NONE))
                    SR_RSP.rdata <= read_value;
                else
                    SR_RSP.rdata <= OWL_ZERO;
            end
        end
    end

    // Decoding uses the registered map, so a write committed at an edge is
    // seen only by instructions taken at later edges.
    assign dec_width = owl_lookup(map_entry, DEC_REQ.width_field); // [RULE_01] [RULE_15]
    assign dec_width_bits = {dec_width, 3'b000};
    assign dec_too_wide = (dec_width > WIDEST_BYTES)
                          || (DEC_REQ.simd
                              && (dec_width_bits > {3'b000, SIMD_LIMIT_BITS})); // [RULE_14]

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            DEC_RSP <= '0;
        end
        else if (CE)
        begin
            DEC_RSP.valid <= DEC_REQ.valid; // [RULE_13]
            if (DEC_REQ.valid)
            begin
                DEC_RSP.width_bytes <= dec_width; // [RULE_01]
                DEC_RSP.simd <= DEC_REQ.simd; // [RULE_10]
                DEC_RSP.trap <= dec_too_wide; // [RULE_14]
            end
        end
    end

endmodule
`default_nettype wire

// >>> sim/owl_stream_model.sv
// Instruction stream model that offers at most one decode request per cycle.
`timescale 1ns/1ps
`default_nettype none
module owl_stream_model
    import owl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output var owl_dec_req_t req
);
    initial req = '0;
    // Quiet in reset, then a random mix of idle slots and data instructions.
    // The stream has no special register path, so it never rewrites the map.
    always @(posedge clk)
        req <= rst ? '0 : '{($urandom % 4) != 0, 2'($urandom), 1'($urandom)};
endmodule
`default_nettype wire

// >>> sim/owl_decoder_asserts.sv
// Concurrent checks on the ports of the operand width lookup decoder.
`timescale 1ns/1ps
`default_nettype none
module owl_chk
    import owl_pkg::*;
#(
    parameter logic [15:0] WIDEST_BYTES = OWL_WIDEST_RESET,
    parameter logic [15:0] SIMD_LIMIT_BITS = OWL_SIMD_LIMIT_RESET
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire owl_dec_req_t DEC_REQ,
    input wire owl_dec_rsp_t DEC_RSP,
    input wire owl_sr_req_t SR_REQ,
    input wire logic SR_PRIV,
    input wire logic SR_READY,
    input wire owl_sr_rsp_t SR_RSP
);
    logic take;
    assign take = CE && SR_READY && SR_REQ.valid;
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    dec_answer_a: assert property (CE && DEC_REQ.valid |=> DEC_RSP.valid)
        else $error("decode answer missing");
    dec_simd_a: assert property (CE && DEC_REQ.valid |=> DEC_RSP.simd == $past(DEC_REQ.simd))
        else $error("simd flag lost");
    dec_trap_a: assert property (DEC_RSP.valid |-> DEC_RSP.trap == ((DEC_RSP.width_bytes >
        WIDEST_BYTES) || (DEC_RSP.simd && {DEC_RSP.width_bytes, 3'b000} > {3'b000, SIMD_LIMIT_BITS})))
        else $error("width trap wrong");
    sr_answer_a: assert property (take ##1 CE [*2] |=> SR_RSP.valid)
        else $error("access answer late");
    sr_busy_a: assert property (take |=> !SR_READY [*2])
        else $error("second access accepted");
    widest_read_a: assert property (take && !SR_REQ.write && SR_REQ.index == OWL_SR_WIDEST
        ##1 CE [*2] |=> SR_RSP.rdata == WIDEST_BYTES)
        else $error("widest width wrong");
    no_priv_a: assert property (take && SR_REQ.write && !SR_PRIV && SR_REQ.index <= OWL_SR_MAP_3
        ##1 CE [*2] |=> SR_RSP.trap && SR_RSP.cause == OWL_TRAP_NO_ACCESS)
        else $error("unprivileged write not trapped");
    fault_data_a: assert property (SR_RSP.valid && SR_RSP.trap |-> SR_RSP.rdata == 16'h0000)
        else $error("faulting access returned data");
    freeze_hold_a: assert property (!CE |=> $stable(DEC_RSP) && $stable(SR_RSP) && $stable(SR_READY))
        else $error("outputs moved while clock enable low");
endmodule
bind owl_decoder owl_chk #(.WIDEST_BYTES(WIDEST_BYTES), .SIMD_LIMIT_BITS(SIMD_LIMIT_BITS))
    owl_chk_inst (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .DEC_REQ(DEC_REQ), .DEC_RSP(DEC_RSP),
    .SR_REQ(SR_REQ), .SR_PRIV(SR_PRIV), .SR_READY(SR_READY), .SR_RSP(SR_RSP));
`default_nettype wire

// >>> sim/owl_decoder_tb.sv
// Self-checking bench for the operand width lookup decoder.
`timescale 1ns/1ps
`default_nettype none
module owl_decoder_tb
    import owl_pkg::*;
;
    localparam logic [15:0] WIDE = 16'h0020;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, sr_priv = 1'b0, sr_ready;
    owl_dec_req_t dec_req;
    owl_dec_rsp_t dec_rsp;
    owl_sr_req_t sr_req = '0;
    owl_sr_rsp_t sr_rsp, hw_rsp;
    logic [15:0] shadow [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008};
    logic [15:0] exp_w, pend_val;
    logic exp_t, exp_s, chk_dec = 1'b0, pend_wr = 1'b0;
    logic [1:0] pend_idx;
    int err_total = 0, samples_checked = 0, cycles = 0;
    owl_decoder #(.WIDEST_BYTES(WIDE)) owl_decoder_inst (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
        .DEC_REQ(dec_req), .DEC_RSP(dec_rsp), .SR_REQ(sr_req), .SR_PRIV(sr_priv),
        .SR_READY(sr_ready), .SR_RSP(sr_rsp));
    // The hardwired build sees the same accesses, so its map writes must all fault.
    owl_decoder #(.HARDWIRED(1'b1)) owl_decoder_hw_inst (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
        .DEC_REQ(dec_req), .DEC_RSP(), .SR_REQ(sr_req), .SR_PRIV(sr_priv), .SR_READY(),
        .SR_RSP(hw_rsp));
    owl_stream_model owl_stream_model_inst (.clk(sys_clk), .rst(rst), .req(dec_req));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic sr_op(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
        input logic priv, input owl_trap_t cause, input owl_trap_t hw_cause,
        input logic [15:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        sr_req <= '{1'b1, wr, idx, wd};
        sr_priv <= priv;
        // Pending write details change only between edges, so the shadow decode
        // process reads them race free at the edge that shows the answer.
        pend_idx <= idx[1:0];
        pend_val <= wd;
        pend_wr <= wr && cause == OWL_TRAP_NONE;
        @(posedge sys_clk);
        sr_req.valid <= 1'b0;
        while (sr_rsp.valid !== 1'b1 && n < 8)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk_val(16'(n), 16'h0003);
        chk_val({13'h0000, sr_rsp.cause}, {13'h0000, cause});
        chk_val({15'h0000, sr_rsp.trap}, {15'h0000, cause != OWL_TRAP_NONE});
        chk_val(sr_rsp.rdata, rd);
        chk_val({13'h0000, hw_rsp.cause}, {13'h0000, hw_cause});
    endtask
    // Shadow decode: a committed write counts from the edge that shows its answer.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (chk_dec)
        begin
            chk_val(dec_rsp.width_bytes, exp_w);
            chk_val({15'h0000, dec_rsp.trap}, {15'h0000, exp_t});
            chk_val({15'h0000, dec_rsp.simd}, {15'h0000, exp_s});
        end
        if (sr_rsp.valid === 1'b1 && pend_wr)
            shadow[pend_idx] = pend_val;
        chk_dec = !rst && ce && dec_req.valid === 1'b1;
        exp_w = shadow[dec_req.width_field];
        exp_s = dec_req.simd;
        exp_t = exp_w > WIDE || (exp_s && {exp_w, 3'b000} > 19'h0_0040);
        if (cycles == 3000)
        begin
            err_total++;
            summarize();
        end
    end
    initial
    begin
        logic [1:0] idx;
        logic [15:0] val;
        void'($urandom(32'h0d9b_1119));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk_val({15'h0000, sr_ready}, 16'h0001);
        for (int i = 0; i < 6; i++)
            sr_op(1'b0, 8'(i), 16'h0000, 1'b0, OWL_TRAP_NONE, OWL_TRAP_NONE,
                i < 4 ? 16'h0001 << i : (i == 4 ? WIDE : 16'h0040));
        sr_op(1'b0, 8'h06, 16'h0000, 1'b1, OWL_TRAP_NO_REG, OWL_TRAP_NO_REG, 16'h0000);
        sr_op(1'b1, 8'(6 + $urandom % 250), 16'h0001, 1'b1, OWL_TRAP_NO_REG, OWL_TRAP_NO_REG,
            16'h0000);
        sr_op(1'b1, 8'h01, 16'h0004, 1'b0, OWL_TRAP_NO_ACCESS, OWL_TRAP_NO_ACCESS, 16'h0000);
        sr_op(1'b1, 8'h04, 16'h0004, 1'b1, OWL_TRAP_HARDWIRED, OWL_TRAP_HARDWIRED, 16'h0000);
        sr_op(1'b1, 8'h05, 16'h0020, 1'b1, OWL_TRAP_HARDWIRED, OWL_TRAP_HARDWIRED, 16'h0000);
        sr_op(1'b1, 8'h02, 16'h0003, 1'b1, OWL_TRAP_INCOHERENT, OWL_TRAP_HARDWIRED, 16'h0000);
        sr_op(1'b1, 8'h03, 16'h0040, 1'b1, OWL_TRAP_INCOHERENT, OWL_TRAP_HARDWIRED, 16'h0000);
        sr_op(1'b1, 8'h00, WIDE, 1'b1, OWL_TRAP_NONE, OWL_TRAP_HARDWIRED, 16'h0000);
        for (int k = 0; k < 8; k++)
        begin
            idx = 2'($urandom);
            val = 16'h0001 << ($urandom % 6);
            sr_op(1'b1, {6'h00, idx}, val, 1'b1, OWL_TRAP_NONE, OWL_TRAP_HARDWIRED, 16'h0000);
            sr_op(1'b0, {6'h00, idx}, 16'h0000, 1'b0, OWL_TRAP_NONE, OWL_TRAP_NONE, val);
        end
        ce <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ce <= 1'b1;
        repeat (20) @(posedge sys_clk);
        summarize();
    end
endmodule
`default_nettype wire
